// ==== design/rfreg_params.svh ====
// Register offsets, field positions and timing counts of the radio
// control bank. Included by the design modules and the testbench.
`ifndef RFREG_PARAMS_SVH
`define RFREG_PARAMS_SVH

// ************************************************************
// Register addresses (7-bit SPI register number)
// ************************************************************
`define RFREG_A_LOCK      7'h03
`define RFREG_A_STRENGTH  7'h06
`define RFREG_A_START     7'h07
`define RFREG_A_AMP       7'h09
`define RFREG_A_OSC       7'h0a
`define RFREG_A_TEST      7'h0b
`define RFREG_A_VCO       7'h17
`define RFREG_A_SLEEP     7'h1b
`define RFREG_A_REV       7'h1d
`define RFREG_A_SIG       7'h1e
`define RFREG_A_SID       7'h1f

// ************************************************************
// Field positions
// ************************************************************
`define RFREG_B_LOCK      12
`define RFREG_B_TX        8
`define RFREG_B_RX        7
`define RFREG_B_CW        15
`define RFREG_B_SDIS      9
`define RFREG_B_VCO       2
`define RFREG_B_OSC       0

// ************************************************************
// Reset values and arbitrary identity values
// ************************************************************
`define RFREG_R_START     16'h0000
`define RFREG_R_AMP       16'h0000
`define RFREG_R_OSC       16'h0001
`define RFREG_R_TEST      16'h0000
`define RFREG_R_VCO       16'h0000
`define RFREG_R_SLEEP     16'h0000
// Arbitrary neutral identity values
`define RFREG_ID_SIG      16'h5a5a
`define RFREG_ID_SID      16'h0101
`define RFREG_ID_RF       4'h1
`define RFREG_ID_DIG      3'h1

// ************************************************************
// Timing
// ************************************************************
`define RFREG_CLK_MHZ     25
`define RFREG_CAL_NS      1000
`define RFREG_CAL_CYC     ((`RFREG_CAL_NS * `RFREG_CLK_MHZ) / 1000)

`endif

// ==== design/rfreg_pkg.sv ====
// Types shared by the radio control bank.
// Assumes rfreg_params.svh is on the include path.
package rfreg_pkg;

  // Settings handed to the analog radio
  typedef struct packed {
    logic [6:0] channel_number;
    logic [3:0] amplifier_gain;
    logic       oscillator_gain_on;
    logic       unmodulated_carrier;
    logic       strength_measure_off;
    logic [4:0] sleep_regulator_setting;
  } rfreg_cfg_t;

  // Status arriving from the analog radio
  typedef struct packed {
    logic       synth_locked;
    logic [5:0] raw_signal_strength;
  } rfreg_stat_t;

  // Radio sequencer states
  typedef enum logic [3:0] {
    RFREG_IDLE = 4'b0001,
    RFREG_CAL  = 4'b0010,
    RFREG_TX   = 4'b0100,
    RFREG_RX   = 4'b1000
  } rfreg_state_t;

endpackage

// ==== design/rfreg_spi.sv ====
// SPI slave front end: 8-bit command (r/w bit, 7-bit address)
// then 16 data bits, MSB first, mode 0. Pins are synchronised
// here with three flip-flops; spi clock is far below clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "rfreg_params.svh"

module rfreg_spi (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Pins
  input  wire logic        sck_i,
  input  wire logic        ss_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // Register side
  output logic [6:0]       addr_o,
  output logic             rd_req_o,
  input  wire logic [15:0] rd_data_i,
  output logic             wr_o,
  output logic [15:0]      wr_data_o
);

  logic [2:0]  sck_r, ss_r, mosi_r;
  logic        sck_rise, sck_fall, sel;
  logic [4:0]  cnt_r;
  logic [7:0]  cmd_r;
  logic [15:0] sh_r;
  logic [15:0] tx_r;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Stage 0 is read only by stage 1
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_r  <= 3'h0;
      ss_r   <= 3'h7;
      mosi_r <= 3'h0;
    end else begin
      sck_r  <= {sck_r[1:0], sck_i};
      ss_r   <= {ss_r[1:0], ss_n_i};
      mosi_r <= {mosi_r[1:0], mosi_i};
    end
  end

  assign sck_rise = sck_r[1] & ~sck_r[2];
  assign sck_fall = ~sck_r[1] & sck_r[2];
  assign sel      = ~ss_r[1] & ~ss_r[2];

  // ************************************************************
  // Shift engine
  // ************************************************************
  // Bit counter and shifters; deselect aborts a frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r     <= 5'h00;
      cmd_r     <= 8'h00;
      sh_r      <= 16'h0000;
      tx_r      <= 16'h0000;
      rd_req_o  <= 1'b0;
      wr_o      <= 1'b0;
      addr_o    <= 7'h00;
      wr_data_o <= 16'h0000;
    end else begin
      rd_req_o <= 1'b0;
      wr_o     <= 1'b0;
      if (!sel) begin
        cnt_r <= 5'h00;
      end else if (sck_rise) begin
        cnt_r <= (cnt_r == 5'd23) ? 5'h00 : cnt_r + 5'h01;
        if (cnt_r < 5'd8) begin
          cmd_r <= {cmd_r[6:0], mosi_r[2]};
        end else begin
          sh_r <= {sh_r[14:0], mosi_r[2]};
        end
        if (cnt_r == 5'd7) begin
          addr_o   <= {cmd_r[5:0], mosi_r[2]};
          rd_req_o <= cmd_r[6];             // Read when top bit set
        end
        if (cnt_r == 5'd23 && !cmd_r[7]) begin
          wr_o      <= 1'b1;
          wr_data_o <= {sh_r[14:0], mosi_r[2]};
        end
      end
      if (rd_req_o) begin
        tx_r <= rd_data_i;
      end else if (sel && sck_fall && cnt_r > 5'd8) begin
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

  // Drive MISO only while selected
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      miso_o    <= tx_r[15];
      miso_oe_o <= sel;
    end
  end

endmodule // rfreg_spi

`default_nettype wire

// ==== design/rfreg_bank.sv ====
// Radio control and status register bank behind an SPI slave.
// Assumes a host SPI master in mode 0 with sck well below clk_i/6,
// and an analog radio that supplies lock and signal strength.
// Every output leaves a flip-flop; status levels pass three stages
// before they are read, so a read trails the analog pins slightly.
`timescale 1ns/1ps
`default_nettype none
`include "rfreg_params.svh"

module rfreg_bank #(
  parameter int CAL_CYCLES = `RFREG_CAL_CYC
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // SPI pins
  input  wire logic                sck_i,
  input  wire logic                ss_n_i,
  input  wire logic                mosi_i,
  output logic                     miso_o,
  output logic                     miso_oe_o,
  // Analog status
  input  wire rfreg_pkg::rfreg_stat_t stat_i,
  // Analog controls
  output rfreg_pkg::rfreg_cfg_t    cfg_o,
  output logic                     tx_on_o,
  output logic                     rx_on_o,
  output logic                     vco_cal_o
);
  import rfreg_pkg::*;

  logic [6:0]   addr;
  logic         rd_req, wr;
  logic [15:0]  wr_data, rd_data;
  logic [15:0]  start_r, amp_r, osc_r, test_r, vco_r, sleep_r;
  logic [2:0]   lock_r;
  logic [17:0]  str_r;
  logic         lock_hold_r;
  logic [5:0]   str_hold_r;
  logic [15:0]  cal_cnt_r;
  rfreg_state_t state_r, state_nxt;
  logic         go_tx, go_rx;

  // ************************************************************
  // SPI front end
  // ************************************************************
  // Frames are decoded below; this level sees only one-cycle read
  // and write strobes with a stable address
  rfreg_spi u_spi (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .sck_i     (sck_i),
    .ss_n_i    (ss_n_i),
    .mosi_i    (mosi_i),
    .miso_o    (miso_o),
    .miso_oe_o (miso_oe_o),
    .addr_o    (addr),
    .rd_req_o  (rd_req),
    .rd_data_i (rd_data),
    .wr_o      (wr),
    .wr_data_o (wr_data)
  );

  // ************************************************************
  // Analog status synchronisers
  // ************************************************************
  // Analog levels are asynchronous, so three stages each
  // Stage 0 feeds only stage 1
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_r <= 3'h0;
      str_r  <= 18'h00000;
    end else begin
      lock_r <= {lock_r[1:0], stat_i.synth_locked};
      str_r  <= {str_r[11:0], stat_i.raw_signal_strength};
    end
  end

  // A level counts once the second and third stages agree, so a
  // strength word caught mid-change is held back rather than torn
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_hold_r <= 1'b0;
    end else if (lock_r[1] == lock_r[2]) begin
      lock_hold_r <= lock_r[2];
    end
  end

  // Strength word, same agreement rule across all six bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      str_hold_r <= 6'h00;
    end else if (str_r[11:6] == str_r[17:12]) begin
      str_hold_r <= str_r[17:12];
    end
  end

  // ************************************************************
  // Writable registers
  // ************************************************************
  // Only defined fields are stored; reserved bits stay zero, and
  // writes to read-only or unmapped places match no block here
  // Start bits and channel; the host keeps the two starts apart
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_r <= `RFREG_R_START;
    end else if (wr && addr == `RFREG_A_START) begin
      start_r <= wr_data & 16'h01ff;
    end
  end

  // Amplifier level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      amp_r <= `RFREG_R_AMP;
    end else if (wr && addr == `RFREG_A_AMP) begin
      amp_r <= wr_data & 16'h0780;
    end
  end

  // Oscillator gain block enable, on out of reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_r <= `RFREG_R_OSC;
    end else if (wr && addr == `RFREG_A_OSC) begin
      osc_r <= wr_data & 16'h0001;
    end
  end

  // Carrier test and strength measurement disable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_r <= `RFREG_R_TEST;
    end else if (wr && addr == `RFREG_A_TEST) begin
      test_r <= wr_data & 16'h8200;
    end
  end

  // Calibration enable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vco_r <= `RFREG_R_VCO;
    end else if (wr && addr == `RFREG_A_VCO) begin
      vco_r <= wr_data & 16'h0004;
    end
  end

  // Sleep regulator setting
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_r <= `RFREG_R_SLEEP;
    end else if (wr && addr == `RFREG_A_SLEEP) begin
      sleep_r <= wr_data & 16'hf800;
    end
  end

  // ************************************************************
  // Read multiplexer
  // ************************************************************
  // Read-only words are built from live state, never stored
  // Register 6 reads zero while measurement is off, so a stale
  // strength is never mistaken for a live one
  always_comb begin
    case (addr)
      `RFREG_A_LOCK:     rd_data = {3'h0, lock_hold_r, 12'h000};
      `RFREG_A_STRENGTH: rd_data = test_r[`RFREG_B_SDIS] ? 16'h0000
                                   : {str_hold_r, 10'h000};
      `RFREG_A_START:    rd_data = start_r;
      `RFREG_A_AMP:      rd_data = amp_r;
      `RFREG_A_OSC:      rd_data = osc_r;
      `RFREG_A_TEST:     rd_data = test_r;
      `RFREG_A_VCO:      rd_data = vco_r;
      `RFREG_A_SLEEP:    rd_data = sleep_r;
      `RFREG_A_REV:      rd_data = {8'h00, `RFREG_ID_RF, 1'b0,
                                    `RFREG_ID_DIG};
      `RFREG_A_SIG:      rd_data = `RFREG_ID_SIG;
      `RFREG_A_SID:      rd_data = `RFREG_ID_SID;
      default:           rd_data = 16'h0000;
    endcase
  end

  // ************************************************************
  // Radio sequencer
  // ************************************************************
  // Transmit wins if the host breaks the exclusive-start contract
  // rather than leaving both analog paths half started
  assign go_tx = start_r[`RFREG_B_TX];
  assign go_rx = start_r[`RFREG_B_RX] & ~go_tx;

  // Next state; clearing both start bits returns to idle
  // Start bits are levels: the sequencer follows them, not a pulse
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RFREG_IDLE: begin
        if (go_tx || go_rx) begin
          if (vco_r[`RFREG_B_VCO]) begin
            state_nxt = RFREG_CAL;
          end else begin
            state_nxt = go_tx ? RFREG_TX : RFREG_RX;
          end
        end
      end
      RFREG_CAL: begin
        if (!go_tx && !go_rx) begin
          state_nxt = RFREG_IDLE;
        end else if (cal_cnt_r == 16'h0001) begin
          state_nxt = go_tx ? RFREG_TX : RFREG_RX;
        end
      end
      RFREG_TX: begin
        if (!go_tx) begin
          state_nxt = RFREG_IDLE;
        end
      end
      RFREG_RX: begin
        if (!go_rx) begin
          state_nxt = RFREG_IDLE;
        end
      end
      default: state_nxt = RFREG_IDLE;
    endcase
  end

  // State register
  // One-hot, back to idle on reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= RFREG_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Calibration timer, loaded on entry to the calibration state
  // A count of one ends calibration on the next edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_cnt_r <= 16'h0000;
    end else if (state_r != RFREG_CAL && state_nxt == RFREG_CAL) begin
      cal_cnt_r <= 16'(CAL_CYCLES);
    end else if (cal_cnt_r != 16'h0000) begin
      cal_cnt_r <= cal_cnt_r - 16'h0001;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  // Settings to the analog radio
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.channel_number          <= start_r[6:0];
      cfg_o.amplifier_gain          <= amp_r[10:7];
      cfg_o.oscillator_gain_on      <= osc_r[`RFREG_B_OSC];
      cfg_o.unmodulated_carrier     <= test_r[`RFREG_B_CW];
      cfg_o.strength_measure_off    <= test_r[`RFREG_B_SDIS];
      cfg_o.sleep_regulator_setting <= sleep_r[15:11];
    end
  end

  // Sequencer view, taken from the next state so each output moves
  // on the same edge as the state register itself
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_on_o   <= 1'b0;
      rx_on_o   <= 1'b0;
      vco_cal_o <= 1'b0;
    end else begin
      tx_on_o   <= (state_nxt == RFREG_TX);
      rx_on_o   <= (state_nxt == RFREG_RX);
      vco_cal_o <= (state_nxt == RFREG_CAL);
    end
  end

endmodule // rfreg_bank

`default_nettype wire

// ==== dv/rfreg_host.sv ====
// Host SPI master model for the radio register bank.
// Assumes clk_i is the bank clock; sck runs at clk_i/16, mode 0.
`timescale 1ns/1ps
`default_nettype none

module rfreg_host (
  // Clock
  input  wire logic clk_i,
  // SPI pins
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // Idle bus at time zero; sck stands low between frames
  initial begin
    sck_o  = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One 24-bit frame; callers never set both start bits
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    rd = 16'h0000;
    @(posedge clk_i);
    ss_n_o <= 1'b0;
    mosi_o <= sh[23];
    for (int i = 0; i < 24; i++) begin
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b1;
      if (i >= 8) rd = {rd[14:0], miso_i};
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b0;
      if (i < 23) mosi_o <= sh[22-i];
    end
    repeat (8) @(posedge clk_i);
    ss_n_o <= 1'b1;
    // Released data line must not keep showing the last bit
    mosi_o <= ~mosi_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // rfreg_host
`default_nettype wire

// ==== dv/rfreg_bank_sva.sv ====
// Pin-level assertions for the radio register bank.
// Assumes CAL_CYCLES is handed down from the bound bank instance.
`timescale 1ns/1ps
`default_nettype none

module rfreg_bank_sva #(
  parameter int CAL_CYCLES = 25
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  ss_n_i,
  input wire rfreg_pkg::rfreg_cfg_t cfg_o,
  input wire logic                  tx_on_o,
  input wire logic                  rx_on_o,
  input wire logic                  vco_cal_o
);
  import rfreg_pkg::*;
  logic [7:0] cal_len_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Length of the running calibration pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cal_len_r <= 8'h00;
    else if (vco_cal_o) cal_len_r <= cal_len_r + 8'h01;
    else cal_len_r <= 8'h00;
  end

  // Settings only move inside a write frame
  a_chan_in_frame: assert property (
    $changed(cfg_o.channel_number) |-> !ss_n_i && !$past(ss_n_i, 6))
    else $error("channel changed outside a frame");
  a_amp_in_frame: assert property (
    $changed(cfg_o.amplifier_gain) |-> !ss_n_i)
    else $error("amplifier level changed outside a frame");
  a_cw_in_frame: assert property (
    $changed(cfg_o.unmodulated_carrier) |-> !$past(ss_n_i, 2))
    else $error("carrier mode changed outside a frame");
  a_sdis_hold: assert property (
    ss_n_i [*2] |-> $stable(cfg_o.strength_measure_off))
    else $error("strength disable moved while deselected");
  a_sleep_in_frame: assert property (
    $changed(cfg_o.sleep_regulator_setting) |-> !$past(ss_n_i, 4))
    else $error("sleep setting changed outside a frame");
  // Sequencer starts only follow a register write
  a_start_in_frame: assert property (
    $rose(tx_on_o) || $rose(rx_on_o) |-> !$past(ss_n_i, 8))
    else $error("sequencer started without a write");
  a_one_dir: assert property (
    !(tx_on_o && rx_on_o))
    else $error("transmit and receive active together");
  a_cal_quiet: assert property (
    vco_cal_o |-> !tx_on_o && !rx_on_o)
    else $error("calibration overlaps an operation");
  // Long pulses would delay every start made with calibration enabled
  a_cal_bound: assert property (
    vco_cal_o |-> cal_len_r < CAL_CYCLES)
    else $error("calibration longer than its count");
endmodule // rfreg_bank_sva

bind rfreg_bank rfreg_bank_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (
  .clk_i     (clk_i),
  .rst_i     (rst_i),
  .ss_n_i    (ss_n_i),
  .cfg_o     (cfg_o),
  .tx_on_o   (tx_on_o),
  .rx_on_o   (rx_on_o),
  .vco_cal_o (vco_cal_o)
);
`default_nettype wire

// ==== dv/test_radio_rf_control_registers.sv ====
// Self-checking bench for the radio register bank.
// Assumes the package, the bank, the host model and checker compiled.
`timescale 1ns/1ps
`default_nettype none
`include "rfreg_params.svh"

module test_radio_rf_control_registers;
  import rfreg_pkg::*;
  logic        clk_i, rst_i, sck, ss_n, mosi, miso, miso_oe;
  logic        tx_on, rx_on, vco_cal;
  rfreg_stat_t stat;
  rfreg_cfg_t  cfg;
  int          n_errors, checks, cyc;
  logic [15:0] got;
  int          cal_total, cal_base, oe_total, oe_base;
  // Writable places, reset values and implemented bits
  logic [6:0]  rw_a [6] = '{7'h07, 7'h09, 7'h0a, 7'h0b, 7'h17, 7'h1b};
  logic [15:0] rw_r [6] = '{16'h0000, 16'h0000, 16'h0001,
                            16'h0000, 16'h0000, 16'h0000};
  logic [15:0] rw_m [6] = '{16'h01ff, 16'h0780, 16'h0001,
                            16'h8200, 16'h0004, 16'hf800};
  logic [6:0]  ro_a [5] = '{7'h03, 7'h1d, 7'h1e, 7'h1f, 7'h40};

  // 25 MHz clock
  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;

  rfreg_bank #(.CAL_CYCLES(4)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .ss_n_i(ss_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .stat_i(stat),
    .cfg_o(cfg), .tx_on_o(tx_on), .rx_on_o(rx_on), .vco_cal_o(vco_cal));
  rfreg_host u_host (
    .clk_i(clk_i), .sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi),
    .miso_i(miso));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_host.xfer({1'b0, a}, d, got);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    u_host.xfer({1'b1, a}, 16'h0000, got);
    chk(got, exp);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard and pulse counters; about 18900 cycles are needed
  always @(posedge clk_i) begin
    cyc++;
    if (vco_cal) cal_total++;
    if (miso_oe) oe_total++;
    if (cyc == 40000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    rst_i <= 1'b1;
    stat <= '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 6; i++) rd(rw_a[i], rw_r[i]);
    stat <= '{synth_locked: 1'b1, raw_signal_strength: 6'h2b};
    oe_base = oe_total;
    rd(7'h03, 16'h1000);
    chk({14'h0000, oe_total != oe_base, miso_oe}, 16'h0002);
    rd(7'h06, 16'hac00);
    stat <= '{synth_locked: 1'b0, raw_signal_strength: 6'h15};
    rd(7'h03, 16'h0000);
    rd(7'h06, 16'h5400);
    // Read-only and unmapped places ignore writes
    for (int i = 0; i < 5; i++) wr(ro_a[i], 16'hffff);
    rd(7'h1d, {8'h00, `RFREG_ID_RF, 1'b0, `RFREG_ID_DIG});
    rd(7'h1e, `RFREG_ID_SIG);
    rd(7'h1f, `RFREG_ID_SID);
    rd(7'h40, 16'h0000);
    rd(7'h03, 16'h0000);
    // All ones leave only the implemented bits
    for (int i = 1; i < 6; i++) begin
      wr(rw_a[i], 16'hffff);
      rd(rw_a[i], rw_m[i]);
    end
    chk({4'h0, cfg.amplifier_gain, cfg.oscillator_gain_on,
         cfg.unmodulated_carrier, cfg.strength_measure_off,
         cfg.sleep_regulator_setting}, 16'h0fff);
    rd(7'h06, 16'h0000);
    for (int i = 1; i < 6; i++) wr(rw_a[i], 16'h0000);
    chk({4'h0, cfg.amplifier_gain, cfg.oscillator_gain_on,
         cfg.unmodulated_carrier, cfg.strength_measure_off,
         cfg.sleep_regulator_setting}, 16'h0000);
    rd(7'h06, 16'h5400);
    // Transmit, back to idle, then receive
    wr(7'h07, 16'h014e);
    chk({cfg.channel_number, 7'h00, tx_on, rx_on}, 16'h9c02);
    rd(7'h07, 16'h014e);
    wr(7'h07, 16'h0027);
    chk({cfg.channel_number, 7'h00, tx_on, rx_on}, 16'h4e00);
    wr(7'h07, 16'h00a7);
    chk({cfg.channel_number, 7'h00, tx_on, rx_on}, 16'h4e01);
    wr(7'h07, 16'h0000);
    // Calibration of the set count ahead of a start, none when off
    wr(7'h17, 16'h0004);
    cal_base = cal_total;
    wr(7'h07, 16'h0100);
    chk({14'(cal_total - cal_base), tx_on, rx_on}, 16'h0012);
    wr(7'h07, 16'h0000);
    wr(7'h17, 16'h0000);
    cal_base = cal_total;
    wr(7'h07, 16'h0080);
    chk({14'(cal_total - cal_base), tx_on, rx_on}, 16'h0001);
    test_done();
  end
endmodule // test_radio_rf_control_registers
`default_nettype wire
